/* File: shared/tocol_pkg.sv */
// Purpose: Constants for the trip output collector: register map, fields, reset values.
// Assumes: 32-bit AXI4-Lite register bus, 100 MHz clock.
// Notes: Delays are programmed in clock cycles by software.
//
// Summary of operation
// - In three-pole-only mode any trip request trips all three phases together.
// - Mixed mode trips all phases unless a single-phase-to-ground fault is identified.
// - Single-pole trips always start reclosing; three-pole trips only when enabled or when a reclose input requests it.
// - Single-pole tripping is allowed only while the recloser is in reset.
// - Trip outputs are also driven as breaker failure initiate signals.
// - Six selectable three-pole request inputs always force a three-pole trip.
// - Six selectable single-pole inputs; the phase comes from the phase selector.
// - Six selectable reclose inputs trip three poles and start three-pole reclosing.
// - The force-three-pole input turns single-pole requests into three-pole trips.
// - While the recloser force is high, a held single-pole request trips three poles.
// - While reverse-fault is high, trip assertion waits the evolving-fault delay.
// - Trip outputs are withheld for the channel wait delay after a request appears.
package tocol_pkg;
  localparam int          NUM_IN          = 6;
  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_SEL        = 8'h04;
  localparam logic [7:0]  ADDR_COMM_DLY   = 8'h08;
  localparam logic [7:0]  ADDR_EVOLV_DLY  = 8'h0c;
  localparam logic [7:0]  ADDR_STATUS     = 8'h10;
  localparam int          CTRL_MODE_BIT   = 0;
  localparam int          CTRL_AR3P_BIT   = 1;
  localparam logic [1:0]  CTRL_RESET      = 2'h0;
  localparam int          SEL_3P_LSB      = 0;
  localparam int          SEL_1P_LSB      = 8;
  localparam int          SEL_RC_LSB      = 16;
  localparam logic [23:0] SEL_RESET       = 24'h000000;
  localparam logic [15:0] DLY_RESET       = 16'h0000;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  localparam logic [1:0]  FT_AG           = 2'h1;
  localparam logic [1:0]  FT_BG           = 2'h2;
  localparam logic [1:0]  FT_CG           = 2'h3;
endpackage

/* File: design/tocol_top.sv */
// Purpose: Trip output collector with AXI4-Lite settings registers.
// Assumes: All request inputs are synchronous to aclk.
// Notes: Outputs are registered; a trip decision reaches the pins one cycle after it is made.
`timescale 1ns/1ps
module tocol_top
  import tocol_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [5:0]  req_three_pole,
  input  wire logic [5:0]  req_single_pole,
  input  wire logic [5:0]  req_reclose,
  input  wire logic        force_three_pole,
  input  wire logic        recloser_force_all_phases,
  input  wire logic        recloser_in_reset,
  input  wire logic [1:0]  fault_type,
  input  wire logic        reverse_fault,
  output logic [2:0]       trip_phase,
  output logic             trip_three_pole_op,
  output logic             trip_single_pole_op,
  output logic             reclose_init_three_pole,
  output logic             reclose_init_single_pole,
  output logic [2:0]       bf_initiate
);

  logic [1:0]  ctrl_r;
  logic [23:0] sel_r;
  logic [15:0] channel_wait_delay_r;
  logic [15:0] evolving_fault_delay_r;
  logic        aw_hold_r;
  logic        w_hold_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic [15:0] comm_cnt_r;
  logic [15:0] evolv_cnt_r;

  logic [5:0]  en_3p;
  logic [5:0]  en_1p;
  logic [5:0]  en_rc;
  logic        any_3p;
  logic        any_1p;
  logic        any_rc;
  logic        any_req;
  logic        slg_fault;
  logic        single_ok;
  logic        comm_done;
  logic        evolv_done;
  logic        release_trip;
  logic        do_write;
  logic [2:0]  phase_nxt;
  logic        three_nxt;
  logic        single_nxt;
  logic        wr_hit;
  logic        rd_err;
  logic [31:0] rd_word;
  logic [31:0] status_word;

  // One generate loop masks each request input with its selection bit.
  for (genvar i = 0; i < NUM_IN; i++) begin : g_sel
    assign en_3p[i] = req_three_pole[i] & sel_r[SEL_3P_LSB + i];
    assign en_1p[i] = req_single_pole[i] & sel_r[SEL_1P_LSB + i];
    assign en_rc[i] = req_reclose[i] & sel_r[SEL_RC_LSB + i];
  end

  assign any_3p  = |en_3p;
  assign any_1p  = |en_1p;
  assign any_rc  = |en_rc;
  assign any_req = any_3p | any_1p | any_rc;

  assign slg_fault = (fault_type == FT_AG) || (fault_type == FT_BG) || (fault_type == FT_CG);

  // Single-pole needs mixed mode, a ground fault, an idle recloser, and nothing forcing three poles.
  assign single_ok = ctrl_r[CTRL_MODE_BIT] & slg_fault
                   & recloser_in_reset
                   & ~any_3p & ~any_rc
                   & ~force_three_pole
                   & ~recloser_force_all_phases;

  // The channel wait timer counts while requests stand, the evolving-fault timer only while reverse_fault also stands; both restart when no request is present.
  assign comm_done  = (comm_cnt_r >= channel_wait_delay_r);
  assign evolv_done = ~reverse_fault | (evolv_cnt_r >= evolving_fault_delay_r);
  assign release_trip = any_req & comm_done & evolv_done;

  // A single-pole decision needs a located ground fault; any doubt falls back to all three poles.
  always_comb begin
    phase_nxt  = 3'b000;
    three_nxt  = 1'b0;
    single_nxt = 1'b0;
    if (release_trip) begin
      if (any_1p && single_ok) begin
        single_nxt = 1'b1;
        unique case (fault_type)
          FT_AG:   phase_nxt = 3'b001;
          FT_BG:   phase_nxt = 3'b010;
          default: phase_nxt = 3'b100;
        endcase
      end else begin
        three_nxt = 1'b1;
        phase_nxt = 3'b111;
      end
    end
  end

  // Each timer restarts whenever the request set empties, so a new fault never inherits an old count.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      comm_cnt_r <= 16'h0000;
    end else if (!any_req) begin
      comm_cnt_r <= 16'h0000;
    end else if (!comm_done) begin
      comm_cnt_r <= comm_cnt_r + 16'h0001;
    end
  end

  // The evolving-fault timer only runs while reverse_fault stands; dropping it releases the trip at once.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evolv_cnt_r <= 16'h0000;
    end else if (!any_req || !reverse_fault) begin
      evolv_cnt_r <= 16'h0000;
    end else if (evolv_cnt_r < evolving_fault_delay_r) begin
      evolv_cnt_r <= evolv_cnt_r + 16'h0001;
    end
  end

  // Trip pins are registered so a glitch on a request input never reaches the breaker.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trip_phase          <= 3'b000;
      trip_three_pole_op  <= 1'b0;
      trip_single_pole_op <= 1'b0;
    end else begin
      trip_phase          <= phase_nxt;
      trip_three_pole_op  <= three_nxt;
      trip_single_pole_op <= single_nxt;
    end
  end

  // Reclose inputs start three-pole reclosing even when the control bit leaves it off.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reclose_init_three_pole  <= 1'b0;
      reclose_init_single_pole <= 1'b0;
    end else begin
      reclose_init_single_pole <= single_nxt;
      reclose_init_three_pole  <= three_nxt & (ctrl_r[CTRL_AR3P_BIT] | any_rc);
    end
  end

  // Breaker failure initiate is fed from the same next-trip vector, so it can never lag the trip pins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bf_initiate <= 3'b000;
    end else begin
      bf_initiate <= phase_nxt;
    end
  end

  // AXI4-Lite write: address and data are latched independently, then one write and one response.
  // A held address or data beat blocks its channel until the register update, so nothing is overwritten.
  assign do_write = aw_hold_r & w_hold_r & ~s_axi_bvalid;
  assign wr_hit   = (awaddr_r == ADDR_CTRL) || (awaddr_r == ADDR_SEL) ||
                    (awaddr_r == ADDR_COMM_DLY) || (awaddr_r == ADDR_EVOLV_DLY);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r     <= 1'b0;
      awaddr_r      <= 8'h00;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_hold_r & ~s_axi_awready & s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end else if (do_write) begin
        aw_hold_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_r     <= 1'b0;
      wdata_r      <= 32'h00000000;
      wstrb_r      <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= ~w_hold_r & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end else if (do_write) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Each settings register has its own process; byte strobes let software change one select field alone.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RESET;
    end else if (do_write && (awaddr_r == ADDR_CTRL) && wstrb_r[0]) begin
      ctrl_r <= wdata_r[1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_r <= SEL_RESET;
    end else if (do_write && (awaddr_r == ADDR_SEL)) begin
      if (wstrb_r[0]) sel_r[7:0]   <= wdata_r[7:0];
      if (wstrb_r[1]) sel_r[15:8]  <= wdata_r[15:8];
      if (wstrb_r[2]) sel_r[23:16] <= wdata_r[23:16];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_wait_delay_r <= DLY_RESET;
    end else if (do_write && (awaddr_r == ADDR_COMM_DLY)) begin
      if (wstrb_r[0]) channel_wait_delay_r[7:0]  <= wdata_r[7:0];
      if (wstrb_r[1]) channel_wait_delay_r[15:8] <= wdata_r[15:8];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evolving_fault_delay_r <= DLY_RESET;
    end else if (do_write && (awaddr_r == ADDR_EVOLV_DLY)) begin
      if (wstrb_r[0]) evolving_fault_delay_r[7:0]  <= wdata_r[7:0];
      if (wstrb_r[1]) evolving_fault_delay_r[15:8] <= wdata_r[15:8];
    end
  end

  // AXI4-Lite read: one cycle from address acceptance to data.
  assign status_word = {24'h000000, trip_three_pole_op, trip_single_pole_op, any_req, comm_done, evolv_done,
                        trip_phase};

  // The address is decoded while the master holds it, so the registered answer needs no second stage.
  always_comb begin
    rd_word = 32'h00000000;
    rd_err  = 1'b0;
    unique case (s_axi_araddr)
      ADDR_CTRL:      rd_word = {30'h0, ctrl_r};
      ADDR_SEL:       rd_word = {8'h00, sel_r};
      ADDR_COMM_DLY:  rd_word = {16'h0000, channel_wait_delay_r};
      ADDR_EVOLV_DLY: rd_word = {16'h0000, evolving_fault_delay_r};
      ADDR_STATUS:    rd_word = status_word;
      default:        rd_err  = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

/* File: test/tocol_partner.sv */
// Purpose: Recloser stand-in for the trip collector bench.
// Assumes: HALF_CYC clocks make half a power system cycle.
// Notes: While hold is high the model stays in reset and ignores reclose starts.
`timescale 1ns/1ps
module tocol_partner #(
  parameter int HALF_CYC = 4
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic hold,
  input  wire logic reclose_init_single_pole,
  output logic      recloser_force_all_phases,
  output logic      recloser_in_reset
);
  int cnt_r;

  always_ff @(posedge aclk) begin
    if (!aresetn || hold) begin
      cnt_r                     <= 0;
      recloser_in_reset         <= 1'b1;
      recloser_force_all_phases <= 1'b0;
    end else if (reclose_init_single_pole || !recloser_in_reset) begin
      recloser_in_reset <= 1'b0;
      cnt_r             <= cnt_r + 1;
      if (cnt_r == 3 * HALF_CYC - 1) begin
        recloser_force_all_phases <= 1'b1;
      end
    end
  end
endmodule

/* File: test/tocol_properties.sv */
// Purpose: Port assertions for the trip output collector.
// Assumes: One clock domain with synchronous active-low reset.
// Notes: Registered outputs reflect the inputs of the previous edge.
`timescale 1ns/1ps
module tocol_properties (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       force_three_pole,
  input wire logic       recloser_force_all_phases,
  input wire logic       recloser_in_reset,
  input wire logic [2:0] trip_phase,
  input wire logic       trip_three_pole_op,
  input wire logic       trip_single_pole_op,
  input wire logic       reclose_init_single_pole,
  input wire logic       reclose_init_three_pole,
  input wire logic [2:0] bf_initiate
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_bf_mirror: assert property (bf_initiate == trip_phase)
    else $error("breaker failure initiate differs from trip");
  a_three_all: assert property (trip_three_pole_op |-> trip_phase == 3'h7)
    else $error("three-pole trip without all phases");
  a_single_one: assert property (trip_single_pole_op |-> $onehot(trip_phase) && !trip_three_pole_op)
    else $error("single-pole trip not on exactly one phase");
  a_single_recl: assert property (trip_single_pole_op |-> reclose_init_single_pole)
    else $error("single-pole trip without reclose start");
  a_single_rst: assert property (trip_single_pole_op |-> $past(recloser_in_reset))
    else $error("single-pole trip while recloser busy");
  a_force_conv: assert property ($past(force_three_pole) |-> !trip_single_pole_op)
    else $error("single-pole trip while forced");
  a_ar_force: assert property ($past(recloser_force_all_phases) |-> !trip_single_pole_op)
    else $error("single-pole trip while recloser forces");
  a_reset_clear: assert property (!$past(aresetn) |-> trip_phase == 3'h0 && !trip_three_pole_op)
    else $error("trip outputs active after reset");

  sequence s_force_held;
    force_three_pole ##1 force_three_pole;
  endsequence

  a_rc3_trip: assert property (reclose_init_three_pole |-> trip_three_pole_op)
    else $error("three-pole reclose start without three-pole trip");
  a_force_hold: assert property (s_force_held |=> !trip_single_pole_op)
    else $error("single-pole trip after held force");
endmodule

bind tocol_top tocol_properties i_props (.aclk, .aresetn, .force_three_pole, .recloser_force_all_phases,
  .recloser_in_reset, .trip_phase, .trip_three_pole_op, .trip_single_pole_op, .reclose_init_single_pole,
  .reclose_init_three_pole, .bf_initiate);

/* File: test/tocol_top_bench.sv */
// Purpose: Self-checking bench for the trip output collector.
// Assumes: Delays are programmed to a few cycles to keep the run short.
// Notes: The recloser model stays in reset until its scenario.
`timescale 1ns/1ps
module tocol_top_bench;
  import tocol_pkg::*;
  localparam int HC = 4;
  logic        aclk, aresetn, hold, force_three_pole, reverse_fault, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, fault_type;
  logic [5:0]  req_three_pole, req_single_pole, req_reclose;
  logic [2:0]  trip_phase, bf_initiate;
  logic        trip_three_pole_op, trip_single_pole_op, reclose_init_three_pole, reclose_init_single_pole;
  logic        recloser_force_all_phases, recloser_in_reset;
  int          n_errors = 0, cmp_count = 0;

  tocol_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .req_three_pole, .req_single_pole,
    .req_reclose, .force_three_pole, .recloser_force_all_phases, .recloser_in_reset, .fault_type, .reverse_fault,
    .trip_phase, .trip_three_pole_op, .trip_single_pole_op, .reclose_init_three_pole, .reclose_init_single_pole,
    .bf_initiate);
  tocol_partner #(.HALF_CYC(HC)) i_rec (.aclk, .aresetn, .hold, .reclose_init_single_pole,
    .recloser_force_all_phases, .recloser_in_reset);

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stop_test;
    if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  task automatic tc(input logic [2:0] ph, input logic [3:0] op);
    chk("trip_phase", 32'(ph), 32'(trip_phase));
    chk("bf_initiate", 32'(ph), 32'(bf_initiate));
    chk("ops", 32'(op), 32'({trip_three_pole_op, trip_single_pole_op, reclose_init_three_pole, reclose_init_single_pole}));
  endtask
  task automatic tr(input logic [5:0] r3, r1, rr, input logic [1:0] ft, input int n, input logic [2:0] ph,
                    input logic [3:0] op);
    @(posedge aclk);
    req_three_pole  <= r3;
    req_single_pole <= r1;
    req_reclose     <= rr;
    fault_type      <= ft;
    wt(n);
    tc(ph, op);
  endtask
  // A read passes the expected data in d; the master holds each channel until its own handshake.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [31:0] rd;
    logic [1:0]  rs;
    logic        ha, hw, dn;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata  <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    do begin
      @(negedge aclk);
      ha = w ? s_axi_awvalid && s_axi_awready : s_axi_arvalid && s_axi_arready;
      hw = s_axi_wvalid && s_axi_wready;
      dn = w ? s_axi_bvalid : s_axi_rvalid;
      rs = w ? s_axi_bresp : s_axi_rresp;
      rd = s_axi_rdata;
      @(posedge aclk);
      if (ha) {s_axi_awvalid, s_axi_arvalid} <= 2'b00;
      if (hw) s_axi_wvalid <= 1'b0;
    end while (!dn);
    {s_axi_bready, s_axi_rready} <= 2'b00;
    chk("resp", 32'(er), 32'(rs));
    if (!w) chk("rdata", d, rd);
  endtask

  task automatic s_regs;
    bus(1'b0, ADDR_COMM_DLY, 32'(DLY_RESET), RESP_OKAY);
    bus(1'b0, ADDR_STATUS, 32'h18, RESP_OKAY);
    bus(1'b0, ADDR_CTRL, 32'(CTRL_RESET), RESP_OKAY);
    bus(1'b0, ADDR_SEL, 32'(SEL_RESET), RESP_OKAY);
    bus(1'b0, ADDR_EVOLV_DLY, 32'(DLY_RESET), RESP_OKAY);
    bus(1'b1, 8'h40, 32'h1, RESP_SLVERR);
    bus(1'b0, 8'h40, 32'h0, RESP_SLVERR);
    bus(1'b1, ADDR_SEL, 32'h3f3f3f, RESP_OKAY);
    bus(1'b0, ADDR_SEL, 32'h3f3f3f, RESP_OKAY);
  endtask
  task automatic s_modes;
    for (int i = 0; i < NUM_IN; i++) tr(6'h0, 6'h1 << i, 6'h0, FT_AG, 3, 3'h7, 4'h8);
    bus(1'b1, ADDR_CTRL, 32'h1, RESP_OKAY);
    for (int f = 1; f < 4; f++) tr(6'h0, 6'h20, 6'h0, 2'(f), 3, 3'h1 << (f - 1), 4'h5);
    tr(6'h0, 6'h20, 6'h0, 2'h0, 3, 3'h7, 4'h8);
    for (int i = 0; i < NUM_IN; i++) begin
      tr(6'h1 << i, 6'h1, 6'h0, FT_AG, 3, 3'h7, 4'h8);
      tr(6'h0, 6'h1, 6'h1 << i, FT_AG, 3, 3'h7, 4'ha);
    end
  endtask
  task automatic s_force;
    @(posedge aclk);
    force_three_pole <= 1'b1;
    tr(6'h0, 6'h1, 6'h0, FT_BG, 3, 3'h7, 4'h8);
    @(posedge aclk);
    force_three_pole <= 1'b0;
    bus(1'b1, ADDR_CTRL, 32'h3, RESP_OKAY);
    tr(6'h0, 6'h1, 6'h0, 2'h0, 3, 3'h7, 4'ha);
    tr(6'h0, 6'h0, 6'h0, 2'h0, 3, 3'h0, 4'h0);
  endtask
  task automatic s_delays;
    bus(1'b1, ADDR_COMM_DLY, 32'h5, RESP_OKAY);
    tr(6'h0, 6'h1, 6'h0, FT_AG, 5, 3'h0, 4'h0);
    wt(3);
    tc(3'h1, 4'h5);
    tr(6'h0, 6'h0, 6'h0, 2'h0, 3, 3'h0, 4'h0);
    bus(1'b1, ADDR_COMM_DLY, 32'h0, RESP_OKAY);
    bus(1'b1, ADDR_EVOLV_DLY, 32'(HC), RESP_OKAY);
    @(posedge aclk);
    reverse_fault <= 1'b1;
    tr(6'h0, 6'h1, 6'h0, FT_AG, HC, 3'h0, 4'h0);
    wt(3);
    tc(3'h1, 4'h5);
    @(posedge aclk);
    reverse_fault <= 1'b0;
  endtask
  task automatic s_recl;
    @(posedge aclk);
    hold <= 1'b0;
    wt(20);
    tc(3'h7, 4'ha);
    @(posedge aclk);
    aresetn <= 1'b0;
    wt(2);
    tc(3'h0, 4'h0);
    @(posedge aclk);
    aresetn <= 1'b1;
    hold    <= 1'b1;
    wt(2);
    tc(3'h0, 4'h0);
  endtask

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    {aresetn, force_three_pole, reverse_fault, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, fault_type, req_three_pole, req_single_pole} = '0;
    req_reclose = 6'h0;
    s_axi_wstrb = 4'hf;
    hold        = 1'b1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    wt(1);
    tc(3'h0, 4'h0);
    s_regs;
    s_modes;
    s_force;
    s_delays;
    s_recl;
    stop_test;
  end
  initial begin
    #50us;
    n_errors++;
    stop_test;
  end
endmodule
